// ==== rtl/cme_pkg.sv ====
// package: constants and types for the command-mode escape and pin block
package cme_pkg;
    // register indexes; byte address is four times the index
    localparam logic [5:0] IDX_GUARD_BEFORE = 6'h04;
    localparam logic [5:0] IDX_GUARD_AFTER  = 6'h05;
    localparam logic [5:0] IDX_TIMEOUT      = 6'h06;
    localparam logic [5:0] IDX_EXIT_CMD     = 6'h09;
    localparam logic [5:0] IDX_ESCAPE_CHAR  = 6'h13;
    localparam logic [5:0] IDX_FLOW_CFG     = 6'h1F;
    localparam logic [5:0] IDX_RX_LED_CFG   = 6'h28;
    localparam logic [5:0] IDX_STATUS       = 6'h30;

    // serial opcode that leaves command mode
    localparam logic [7:0] EXIT_OPCODE = 8'h09;

    // accepted ranges and reset values
    localparam logic [7:0]  ESC_MIN         = 8'h20;
    localparam logic [7:0]  ESC_MAX         = 8'h7F;
    localparam logic [7:0]  ESC_RESET       = 8'h2B;
    localparam logic [15:0] TIME_MIN        = 16'h0002;
    localparam logic [15:0] TIMEOUT_RESET   = 16'h00C8;
    localparam logic [15:0] GUARD_BT_RESET  = 16'h000A;
    localparam logic [15:0] GUARD_AT_RESET  = 16'h000A;
    localparam logic [2:0]  LINE_CFG_MAX    = 3'h4;

    // line configuration codes
    localparam logic [2:0] LED_RX_IND    = 3'h0;
    localparam logic [2:0] LED_HIGH      = 3'h1;
    localparam logic [2:0] LED_LOW       = 3'h2;
    localparam logic [2:0] LED_ADDR_TX   = 3'h4;
    localparam logic [2:0] FLOW_CTS      = 3'h0;
    localparam logic [2:0] FLOW_TXEN_LOW = 3'h1;
    localparam logic [2:0] FLOW_IO_HIGH  = 3'h2;
    localparam logic [2:0] FLOW_TXEN_HI  = 3'h3;
    localparam logic [2:0] FLOW_IO_LOW   = 3'h4;

    // status register field
    localparam int STATUS_CMD_BIT = 0;

    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing: one setting unit is 100 ms at a 50 MHz clock
    localparam int UNIT_MS      = 100;
    localparam int CLK_KHZ      = 50000;
    localparam int UNIT_CYCLES  = UNIT_MS * CLK_KHZ;

    // fsm for escape detection and command mode
    typedef enum logic [1:0] {
        CME_IDLE = 2'b00,
        CME_ESC  = 2'b01,
        CME_CMD  = 2'b10
    } cme_state_t;

    // stored settings travel together
    typedef struct packed {
        logic [7:0]  escape_char_setting;
        logic [15:0] command_mode_timeout;
        logic [15:0] guard_time_before;
        logic [15:0] guard_time_after;
        logic [2:0]  rx_led_line_config;
        logic [2:0]  flow_cfg;
    } cme_settings_t;
endpackage

// ==== rtl/cme_top.sv ====
// escape-sequence detector, command mode and output line configuration
// Overview of operation
// R1: escape char accepted only from 0x20 to 0x7F
// R2: escape char resets to 0x2B plus sign
// R3: silence, escape char, silence enters command mode
// R4: escape char selected by opcode 0x13, one byte
// R5: led line: 0 rx indicator, 1 high, 2 low
// R6: led setting 4 asserts on addressed packet send
// R7: exit opcode 0x09 leaves command mode at once
// R8: flow line setting 0 default, drives CTS
// R9: flow setting 1: active-low RS-485 transmit enable
// R10: flow setting 3: active-high RS-485 transmit enable
// R11: flow setting 2 high, 4 low pass-through level
// R12: timeout accepts 0x02 to 0xFFFF, 100 ms units
// R13: timeout resets to 0xC8, twenty seconds
// R14: command mode ends after timeout of inactivity
// R15: timeout selected by opcode 0x06, two bytes
// R16: host keeps line silent for before-guard time
// R17: any received character restarts inactivity timer
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module cme_top #(
    parameter int UNIT_CYCLES = cme_pkg::UNIT_CYCLES,
    parameter int ADDR_W      = 8
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // character stream from the serial receiver
    input  wire logic              rx_valid,
    input  wire logic [7:0]        rx_data,
    // activity inputs for the output lines
    input  wire logic              rf_rx_active,
    input  wire logic              addressed_tx_active,
    input  wire logic              tx_active,
    input  wire logic              host_rx_full,
    // output lines
    output logic                   rx_led_output_line,
    output logic                   flow_control_output_line,
    output logic                   command_mode,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    localparam int CNT_W = $clog2(UNIT_CYCLES + 1);

    cme_pkg::cme_settings_t  set_reg;
    cme_pkg::cme_state_t     state_reg;
    logic [CNT_W-1:0]        unit_cnt_reg;
    logic [15:0]             silence_reg;
    logic [ADDR_W-1:0]       awaddr_reg;
    logic [31:0]             wdata_reg;
    logic [3:0]              wstrb_reg;
    logic                    sw_exit_reg;
    logic                    unit_tick;

    // an address counts as mapped only if its low two bits are 0 and its index names a register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        is_mapped = (addr[1:0] == 2'h0) &&
                    (idx == cme_pkg::IDX_GUARD_BEFORE ||
                     idx == cme_pkg::IDX_GUARD_AFTER  ||
                     idx == cme_pkg::IDX_TIMEOUT      ||
                     idx == cme_pkg::IDX_EXIT_CMD     ||
                     idx == cme_pkg::IDX_ESCAPE_CHAR  ||
                     idx == cme_pkg::IDX_FLOW_CFG     ||
                     idx == cme_pkg::IDX_RX_LED_CFG   ||
                     idx == cme_pkg::IDX_STATUS);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // silence timing

    assign unit_tick = (unit_cnt_reg == CNT_W'(UNIT_CYCLES - 1));

    // any character restarts both counters, so silence is measured exactly
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unit_cnt_reg <= '0;
            silence_reg  <= 16'h0000;
        end else if (rx_valid) begin
            unit_cnt_reg <= '0; // R17
            silence_reg  <= 16'h0000; // R17
        end else if (unit_tick) begin
            unit_cnt_reg <= '0;
            // saturate so long idle spells never wrap back to short ones
            if (silence_reg != 16'hFFFF) begin
                silence_reg <= silence_reg + 16'h0001;
            end
        end else begin
            unit_cnt_reg <= unit_cnt_reg + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // escape sequence and command mode

    // the escape char is only honoured after the host kept the line quiet
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= cme_pkg::CME_IDLE;
        end else begin
            unique case (state_reg)
                cme_pkg::CME_IDLE: begin
                    if (rx_valid &&
                        rx_data == set_reg.escape_char_setting && // R1
                        silence_reg >= set_reg.guard_time_before) begin // R16
                        state_reg <= cme_pkg::CME_ESC; // R3
                    end
                end
                cme_pkg::CME_ESC: begin
                    if (rx_valid) begin
                        state_reg <= cme_pkg::CME_IDLE; // R3
                    end else if (silence_reg >= set_reg.guard_time_after) begin
                        state_reg <= cme_pkg::CME_CMD; // R3
                    end
                end
                cme_pkg::CME_CMD: begin
                    if (rx_valid && rx_data == cme_pkg::EXIT_OPCODE) begin
                        state_reg <= cme_pkg::CME_IDLE; // R7
                    end else if (sw_exit_reg) begin
                        state_reg <= cme_pkg::CME_IDLE; // R7
                    end else if (!rx_valid &&
                        silence_reg >= set_reg.command_mode_timeout) begin
                        state_reg <= cme_pkg::CME_IDLE; // R14
                    end
                end
                default: state_reg <= cme_pkg::CME_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output lines, all registered

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_led_output_line       <= 1'b0;
            flow_control_output_line <= 1'b0;
            command_mode             <= 1'b0;
        end else begin
            command_mode <= (state_reg == cme_pkg::CME_CMD);
            unique case (set_reg.rx_led_line_config)
                cme_pkg::LED_RX_IND:  rx_led_output_line <= rf_rx_active; // R5
                cme_pkg::LED_HIGH:    rx_led_output_line <= 1'b1; // R5
                cme_pkg::LED_LOW:     rx_led_output_line <= 1'b0; // R5
                cme_pkg::LED_ADDR_TX: rx_led_output_line <= addressed_tx_active; // R6
                default:              rx_led_output_line <= 1'b0; // reserved
            endcase
            unique case (set_reg.flow_cfg)
                // clear-to-send is active low: high means hold off
                cme_pkg::FLOW_CTS:      flow_control_output_line <= host_rx_full; // R8
                cme_pkg::FLOW_TXEN_LOW: flow_control_output_line <= ~tx_active; // R9
                cme_pkg::FLOW_IO_HIGH:  flow_control_output_line <= 1'b1; // R11
                cme_pkg::FLOW_TXEN_HI:  flow_control_output_line <= tx_active; // R10
                cme_pkg::FLOW_IO_LOW:   flow_control_output_line <= 1'b0; // R11
                default:                flow_control_output_line <= host_rx_full;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus write channel

    // address and data are caught in either order; the write happens once
    // both are held and no response is pending
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= cme_pkg::RESP_OKAY;
            awaddr_reg    <= '0;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awaddr_reg    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wdata_reg    <= s_axi_wdata;
                wstrb_reg    <= s_axi_wstrb;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(awaddr_reg) ? cme_pkg::RESP_OKAY
                                                      : cme_pkg::RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // settings: out-of-range values are dropped and the old value kept
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            set_reg.escape_char_setting  <= cme_pkg::ESC_RESET; // R2
            set_reg.command_mode_timeout <= cme_pkg::TIMEOUT_RESET; // R13
            set_reg.guard_time_before    <= cme_pkg::GUARD_BT_RESET;
            set_reg.guard_time_after     <= cme_pkg::GUARD_AT_RESET;
            set_reg.rx_led_line_config   <= cme_pkg::LED_RX_IND; // R5
            set_reg.flow_cfg             <= cme_pkg::FLOW_CTS; // R8
            sw_exit_reg                  <= 1'b0;
        end else begin
            sw_exit_reg <= 1'b0;
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid &&
                awaddr_reg[1:0] == 2'h0 && wstrb_reg[0]) begin
                unique case (awaddr_reg[7:2])
                    cme_pkg::IDX_ESCAPE_CHAR: begin // R4
                        if (wdata_reg[7:0] >= cme_pkg::ESC_MIN &&
                            wdata_reg[7:0] <= cme_pkg::ESC_MAX) begin // R1
                            set_reg.escape_char_setting <= wdata_reg[7:0];
                        end
                    end
                    cme_pkg::IDX_TIMEOUT: begin // R15
                        if (wstrb_reg[1] &&
                            wdata_reg[15:0] >= cme_pkg::TIME_MIN) begin // R12
                            set_reg.command_mode_timeout <= wdata_reg[15:0];
                        end
                    end
                    cme_pkg::IDX_GUARD_BEFORE: begin
                        if (wstrb_reg[1] &&
                            wdata_reg[15:0] >= cme_pkg::TIME_MIN) begin
                            set_reg.guard_time_before <= wdata_reg[15:0];
                        end
                    end
                    cme_pkg::IDX_GUARD_AFTER: begin
                        if (wstrb_reg[1] &&
                            wdata_reg[15:0] >= cme_pkg::TIME_MIN) begin
                            set_reg.guard_time_after <= wdata_reg[15:0];
                        end
                    end
                    cme_pkg::IDX_RX_LED_CFG: begin
                        if (wdata_reg[7:0] <= 8'(cme_pkg::LINE_CFG_MAX)) begin
                            set_reg.rx_led_line_config <= wdata_reg[2:0];
                        end
                    end
                    cme_pkg::IDX_FLOW_CFG: begin
                        if (wdata_reg[7:0] <= 8'(cme_pkg::LINE_CFG_MAX)) begin
                            set_reg.flow_cfg <= wdata_reg[2:0];
                        end
                    end
                    cme_pkg::IDX_EXIT_CMD: sw_exit_reg <= 1'b1; // R7
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus read channel

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= cme_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? cme_pkg::RESP_OKAY
                                                     : cme_pkg::RESP_SLVERR;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr[1:0] == 2'h0) begin
                unique case (s_axi_araddr[7:2])
                    cme_pkg::IDX_ESCAPE_CHAR:
                        s_axi_rdata[7:0] <= set_reg.escape_char_setting; // R4
                    cme_pkg::IDX_TIMEOUT:
                        s_axi_rdata[15:0] <= set_reg.command_mode_timeout; // R15
                    cme_pkg::IDX_GUARD_BEFORE:
                        s_axi_rdata[15:0] <= set_reg.guard_time_before;
                    cme_pkg::IDX_GUARD_AFTER:
                        s_axi_rdata[15:0] <= set_reg.guard_time_after;
                    cme_pkg::IDX_RX_LED_CFG:
                        s_axi_rdata[2:0] <= set_reg.rx_led_line_config;
                    cme_pkg::IDX_FLOW_CFG:
                        s_axi_rdata[2:0] <= set_reg.flow_cfg;
                    cme_pkg::IDX_STATUS:
                        s_axi_rdata[cme_pkg::STATUS_CMD_BIT] <=
                            (state_reg == cme_pkg::CME_CMD);
                    default: ;
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule // cme_top

// ==== tb/cme_host.sv ====
// host model: drives the character stream toward the block
`timescale 1ns/100ps
module cme_host (
    input  wire logic       clk,
    output logic            rx_valid,
    output logic [7:0]      rx_data
);
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'hA5;
    end
    // one character per call; stale data is inverted so it never matches
    task automatic send(input logic [7:0] c);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_data  <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~c;
    endtask
    // line held silent for n clock cycles
    task automatic hush(input int n);
        repeat (n) @(posedge clk);
    endtask
endmodule // cme_host

// ==== tb/cme_props.sv ====
// checker: output line and command mode relations of the escape block
`timescale 1ns/100ps
module cme_props #(
    parameter int UNIT_CYCLES = 10,
    parameter int ADDR_W      = 8
) (
    input wire logic              clk,
    input wire logic              sys_rst,
    input wire logic              rx_valid,
    input wire logic [7:0]        rx_data,
    input wire logic              rf_rx_active,
    input wire logic              addressed_tx_active,
    input wire logic              tx_active,
    input wire logic              host_rx_full,
    input wire logic              rx_led_output_line,
    input wire logic              flow_control_output_line,
    input wire logic              command_mode,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid
);
    logic [5:0]  aw_idx;
    logic [15:0] w_val;
    logic        b_d;
    logic [1:0]  up;
    logic [2:0]  sh_flow, sh_led;
    logic [15:0] sh_tmo;
    int          quiet;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // shadow of the line and timeout settings, taken on the first cycle of an OKAY answer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_idx <= 6'h00; w_val <= 16'h0000; b_d <= 1'b0; up <= 2'h0;
            sh_flow <= 3'h0; sh_led <= 3'h0; sh_tmo <= 16'h00C8;
        end else begin
            up <= {up[0], 1'b1};  // masks the edges still seeing reset
            b_d <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) aw_idx <= s_axi_awaddr[7:2];
            if (s_axi_wvalid && s_axi_wready) w_val <= s_axi_wdata[15:0];
            if (s_axi_bvalid && !b_d && s_axi_bresp == 2'h0) begin
                if (aw_idx == cme_pkg::IDX_FLOW_CFG && w_val <= 16'h0004)
                    sh_flow <= w_val[2:0];
                if (aw_idx == cme_pkg::IDX_RX_LED_CFG && w_val <= 16'h0004)
                    sh_led <= w_val[2:0];
                if (aw_idx == cme_pkg::IDX_TIMEOUT && w_val >= 16'h0002)
                    sh_tmo <= w_val;
            end
        end
    end
    // cycles in command mode since the last character
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst || !command_mode || rx_valid) quiet <= 0;
        else quiet <= quiet + 1;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_flow_cts;
        up[1] && sh_flow == 3'h0 && $past(sh_flow) == 3'h0
            |-> flow_control_output_line == $past(host_rx_full);
    endproperty
    property p_flow_txlo;
        up[1] && sh_flow == 3'h1 && $stable(sh_flow)
            |-> flow_control_output_line == !$past(tx_active);
    endproperty
    property p_flow_txhi;
        up[1] && sh_flow == 3'h3 && $stable(sh_flow)
            |-> flow_control_output_line == $past(tx_active);
    endproperty
    property p_flow_io;
        up[1] && (sh_flow == 3'h2 || sh_flow == 3'h4) && $stable(sh_flow)
            |-> flow_control_output_line == (sh_flow == 3'h2);
    endproperty
    property p_led_std;
        up[1] && sh_led <= 3'h2 && $stable(sh_led) |-> rx_led_output_line
            == (sh_led == 3'h0 ? $past(rf_rx_active) : sh_led == 3'h1);
    endproperty
    property p_led_addr;
        up[1] && sh_led == 3'h4 && $stable(sh_led)
            |-> rx_led_output_line == $past(addressed_tx_active);
    endproperty
    property p_exit;
        command_mode && rx_valid && rx_data == cme_pkg::EXIT_OPCODE
            |-> ##[1:3] !command_mode;
    endproperty
    property p_tmo;
        command_mode |-> quiet <= int'(sh_tmo) * UNIT_CYCLES + 4;
    endproperty
    a_flow_cts: assert property (p_flow_cts) else $error("cts line wrong");
    a_flow_txlo: assert property (p_flow_txlo) else $error("low enable");
    a_flow_txhi: assert property (p_flow_txhi) else $error("high enable");
    a_flow_io: assert property (p_flow_io) else $error("flow level");
    a_led_std: assert property (p_led_std) else $error("led line wrong");
    a_led_addr: assert property (p_led_addr) else $error("led addressed");
    a_exit: assert property (p_exit) else $error("no exit on opcode");
    a_tmo: assert property (p_tmo) else $error("timeout overrun");
    c_enter: cover property ($rose(command_mode));
    c_txhi: cover property (sh_flow == 3'h3 && tx_active);
    c_exit: cover property (p_exit);
endmodule // cme_props
bind cme_top cme_props #(.UNIT_CYCLES(UNIT_CYCLES), .ADDR_W(ADDR_W))
    cme_props_inst (.*);

// ==== tb/tb_top.sv ====
// testbench: register, escape sequence and output line scenarios
`timescale 1ns/100ps
module tb_top;
    localparam int U = 10;  // short setting unit keeps the run brief
    logic clk = 1'b0, sys_rst = 1'b1, rx_valid;
    logic rf_rx_active = 1'b0, addressed_tx_active = 1'b0;
    logic tx_active = 1'b0, host_rx_full = 1'b0;
    logic rx_led_output_line, flow_control_output_line, command_mode;
    logic [7:0]  rx_data, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
    logic [31:0] wv[6] = '{32'h2C, 32'h1F, 32'h80, 32'h20, 32'h7F, 32'h2A};
    logic [31:0] ev[6] = '{32'h2B, 32'h2B, 32'h2B, 32'h20, 32'h7F, 32'h2A};
    int bad_count = 0, n_checks = 0;
    cme_host cme_host_inst (.clk, .rx_valid, .rx_data);
    cme_top #(.UNIT_CYCLES(U)) cme_top_inst (.clk, .sys_rst, .rx_valid,
        .rx_data, .rf_rx_active, .addressed_tx_active, .tx_active,
        .host_rx_full, .rx_led_output_line, .flow_control_output_line,
        .command_mode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    // free-running 50 MHz clock
    initial forever #10 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // write one word; address and data are offered together
    task automatic wr(input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] e);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
        s_axi_bready <= 1'b0;
        chk({n < 100, s_axi_bresp}, {1'b1, e});
    endtask
    // read one word and compare data and answer code
    task automatic rd(input logic [5:0] i, input logic [31:0] d,
                      input logic [1:0] e);
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk({n < 100, s_axi_rresp}, {1'b1, e});
    endtask
    // full entry sequence, then wait a bounded time for command mode
    task automatic enter;
        int n = 0;
        cme_host_inst.hush(12 * U);
        cme_host_inst.send(8'h2A);
        while (command_mode !== 1'b1 && n < 8 * U) begin
            @(posedge clk);
            n++;
        end
        chk(command_mode, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rd(cme_pkg::IDX_ESCAPE_CHAR, 32'h2B, 2'h0);
        rd(cme_pkg::IDX_TIMEOUT, 32'hC8, 2'h0);
        rd(cme_pkg::IDX_RX_LED_CFG, 32'h0, 2'h0);
        rd(cme_pkg::IDX_FLOW_CFG, 32'h0, 2'h0);
        rd(6'h3F, 32'h0, 2'h2);
        wr(6'h3F, 32'h1, 2'h2);
        for (int k = 0; k < 6; k++) begin
            s_axi_wstrb <= {3'h7, k != 0};
            wr(cme_pkg::IDX_ESCAPE_CHAR, wv[k], 2'h0);
            rd(cme_pkg::IDX_ESCAPE_CHAR, ev[k], 2'h0);
        end
        wr(cme_pkg::IDX_TIMEOUT, 32'h1, 2'h0);
        rd(cme_pkg::IDX_TIMEOUT, 32'hC8, 2'h0);
        wr(cme_pkg::IDX_TIMEOUT, 32'hFFFF, 2'h0);
        rd(cme_pkg::IDX_TIMEOUT, 32'hFFFF, 2'h0);
        wr(cme_pkg::IDX_TIMEOUT, 32'hC8, 2'h0);
        wr(cme_pkg::IDX_GUARD_AFTER, 32'h2, 2'h0);
        cme_host_inst.hush(12 * U);
        cme_host_inst.send(8'h2B);
        cme_host_inst.hush(6 * U);
        chk(command_mode, 1'b0);
        cme_host_inst.send(8'h41);
        cme_host_inst.send(8'h2A);
        cme_host_inst.hush(6 * U);
        chk(command_mode, 1'b0);
        cme_host_inst.hush(12 * U);
        cme_host_inst.send(8'h2A);
        cme_host_inst.hush(U);
        cme_host_inst.send(8'h41);
        cme_host_inst.hush(6 * U);
        chk(command_mode, 1'b0);
        enter();
        rd(cme_pkg::IDX_STATUS, 32'h1, 2'h0);
        cme_host_inst.send(cme_pkg::EXIT_OPCODE);
        repeat (4) @(posedge clk);
        chk(command_mode, 1'b0);
        wr(cme_pkg::IDX_TIMEOUT, 32'h6, 2'h0);
        enter();
        repeat (3) begin
            cme_host_inst.send(8'h41);
            cme_host_inst.hush(4 * U);
        end
        chk(command_mode, 1'b1);
        cme_host_inst.hush(3 * U);
        chk(command_mode, 1'b0);
        for (int c = 0; c < 5; c++) begin
            wr(cme_pkg::IDX_FLOW_CFG, c, 2'h0);
            wr(cme_pkg::IDX_RX_LED_CFG, c, 2'h0);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                host_rx_full <= v[0];
                rf_rx_active <= v[0];
                tx_active <= !v[0];
                addressed_tx_active <= !v[0];
                repeat (3) @(posedge clk);
                chk(flow_control_output_line, c == 2 || (c < 2 ? v : c == 3 ?
                    !v : 0));
                chk(rx_led_output_line, c == 1 || (c == 0 ? v : c == 4 ?
                    !v : 0));
            end
        end
        conclude();
    end
    // watchdog: the scenarios need well under 10000 cycles
    initial begin
        #200us;
        bad_count++;
        conclude();
    end
endmodule // tb_top
